// ---- src/asr_regs.svh ----
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// register offsets on the management port
`define ASR_TRIP_FLAGS_OFS 8'h26
`define ASR_ROUTE_MASK_OFS 8'h27

// register width
`define ASR_REG_W 24

// field positions, channel 1 at the high end of each group of four
`define ASR_OC_HI 23
`define ASR_OC_LO 20
`define ASR_UC_HI 19
`define ASR_UC_LO 16
`define ASR_OV_HI 15
`define ASR_OV_LO 12
`define ASR_UV_HI 11
`define ASR_UV_LO 8
`define ASR_OP_HI 7
`define ASR_OP_LO 4
`define ASR_ACCUM_OVERFLOW_FLAG_BIT 3
`define ASR_CNT_OVF_BIT 2
`define ASR_CONV_DONE_BIT 1

// reset values
`define ASR_TRIP_FLAGS_RST 24'h000000
`define ASR_ROUTE_MASK_RST 24'h000000

// implemented bits of each register
`define ASR_TRIP_FLAGS_IMPL 24'hfffffc
`define ASR_ROUTE_MASK_IMPL 24'hfffffe

`endif

// ---- src/asr_pkg.sv ----
package asr_pkg;

  typedef logic [23:0] asr_word_t;
  typedef logic [7:0] asr_addr_t;
  typedef logic [3:0] asr_chan_t;

  // clear sequencing: a status read arms, the next conversion completion clears
  typedef enum logic [0:0] {
    ASR_CLR_IDLE,
    ASR_CLR_ARMED
  } asr_clr_state_t;

endpackage

// ---- src/asr_trip_flags.sv ----
`timescale 1ns/10ps
`include "asr_regs.svh"

module asr_trip_flags #(
  parameter int WIDTH = 24
) (
  input wire logic clock_i,              // system clock
  input wire logic rst_i,                // async reset, active high
  input wire logic [WIDTH-1:0] set_i,    // live trip conditions, level
  input wire logic [WIDTH-1:0] clr_i,    // one-cycle clear strobe per bit
  output logic [WIDTH-1:0] flags_o       // sticky flags
);
  import asr_pkg::*;

  logic [WIDTH-1:0] next_flags;

  // a condition present in the clearing cycle keeps its flag
  always_comb begin
    next_flags = (flags_o & ~clr_i) | set_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= WIDTH'(`ASR_TRIP_FLAGS_RST);
    end else begin
      flags_o <= next_flags;
    end
  end

endmodule // asr_trip_flags

// ---- src/asr_pin_route.sv ----
`timescale 1ns/10ps
`include "asr_regs.svh"

module asr_pin_route (
  input wire logic clock_i,                  // system clock
  input wire logic rst_i,                    // async reset, active high
  input wire logic mask_wr_i,                // write strobe for route mask
  input wire asr_pkg::asr_word_t mask_wdata_i, // route mask write data
  input wire asr_pkg::asr_word_t sources_i,  // alert sources, register bit order
  input wire logic alert_function_sel_i,     // pin configured for alert function
  output asr_pkg::asr_word_t route_mask_o,   // first_pin_route_mask contents
  output logic first_alert_pin_o             // pin asserted, active high
);
  import asr_pkg::*;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      route_mask_o <= `ASR_ROUTE_MASK_RST;
    end else if (mask_wr_i) begin
      route_mask_o <= mask_wdata_i & `ASR_ROUTE_MASK_IMPL;
    end
  end

  // when the pin serves its other function the mask has no say
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      first_alert_pin_o <= 1'b0;
    end else begin
      first_alert_pin_o <= alert_function_sel_i & (|(route_mask_o & sources_i));
    end
  end

endmodule // asr_pin_route

// ---- src/asr_top.sv ----
`timescale 1ns/10ps
`include "asr_regs.svh"

module asr_top (
  input wire logic clock_i,                        // system clock, 50 MHz
  input wire logic rst_i,                          // async reset, active high
  input wire asr_pkg::asr_addr_t reg_addr_i,       // register address
  input wire logic reg_wr_i,                       // write strobe, one cycle
  input wire logic reg_rd_i,                       // read strobe, one cycle
  input wire asr_pkg::asr_word_t reg_wdata_i,      // write data
  output asr_pkg::asr_word_t reg_rdata_o,          // read data
  output logic reg_rvalid_o,                       // read data valid, one cycle
  input wire asr_pkg::asr_chan_t chan_overcurrent_i,  // bit 3 = channel 1
  input wire asr_pkg::asr_chan_t chan_undercurrent_i, // bit 3 = channel 1
  input wire asr_pkg::asr_chan_t chan_overvoltage_i,  // bit 3 = channel 1
  input wire asr_pkg::asr_chan_t chan_undervoltage_i, // bit 3 = channel 1
  input wire asr_pkg::asr_chan_t chan_overpower_i,    // bit 3 = channel 1
  input wire logic accum_overflow_i,               // any accumulator overflow/limit
  input wire logic sample_counter_overflow_i,      // sample counter overflow/limit
  input wire logic conversion_done_i,              // conversion cycle complete, pulse
  input wire logic alert_function_sel_i,           // first pin set to alert function
  output logic first_alert_pin_o                   // first alert pin asserted
);
  import asr_pkg::*;

  asr_clr_state_t clr_state;
  asr_clr_state_t next_clr_state;
  asr_word_t trip_set;
  asr_word_t trip_clr;
  asr_word_t trip_flags;
  asr_word_t read_snapshot;
  asr_word_t route_mask;
  asr_word_t pin_sources;
  asr_word_t next_rdata;
  logic status_rd;
  logic route_wr;
  logic clear_now;

  function automatic logic addr_hit(input asr_addr_t addr, input asr_addr_t ofs);
    addr_hit = (addr == ofs);
  endfunction

  // lay the live conditions out in register bit order
  function automatic asr_word_t pack_conditions(
    input asr_chan_t oc,
    input asr_chan_t uc,
    input asr_chan_t ov,
    input asr_chan_t uv,
    input asr_chan_t op,
    input logic acc,
    input logic cnt,
    input logic done
  );
    asr_word_t w;
    w = '0;
    w[`ASR_OC_HI:`ASR_OC_LO] = oc;
    w[`ASR_UC_HI:`ASR_UC_LO] = uc;
    w[`ASR_OV_HI:`ASR_OV_LO] = ov;
    w[`ASR_UV_HI:`ASR_UV_LO] = uv;
    w[`ASR_OP_HI:`ASR_OP_LO] = op;
    w[`ASR_ACCUM_OVERFLOW_FLAG_BIT] = acc;
    w[`ASR_CNT_OVF_BIT] = cnt;
    w[`ASR_CONV_DONE_BIT] = done;
    pack_conditions = w;
  endfunction

  // status readout built field by field; the two low bits carry no function
  function automatic asr_word_t status_view(input asr_word_t flags);
    asr_word_t w;
    w = '0;
    w[`ASR_OC_HI:`ASR_OC_LO] = flags[`ASR_OC_HI:`ASR_OC_LO];
    w[`ASR_UC_HI:`ASR_UC_LO] = flags[`ASR_UC_HI:`ASR_UC_LO];
    w[`ASR_OV_HI:`ASR_OV_LO] = flags[`ASR_OV_HI:`ASR_OV_LO];
    w[`ASR_UV_HI:`ASR_UV_LO] = flags[`ASR_UV_HI:`ASR_UV_LO];
    w[`ASR_OP_HI:`ASR_OP_LO] = flags[`ASR_OP_HI:`ASR_OP_LO];
    w[`ASR_ACCUM_OVERFLOW_FLAG_BIT] = flags[`ASR_ACCUM_OVERFLOW_FLAG_BIT];
    w[`ASR_CNT_OVF_BIT] = flags[`ASR_CNT_OVF_BIT];
    status_view = w & `ASR_TRIP_FLAGS_IMPL;
  endfunction

  // sources the route mask may select, in mask bit order; bit 0 has no source
  function automatic asr_word_t route_view(input asr_word_t bits);
    asr_word_t w;
    w = '0;
    w[`ASR_OC_HI:`ASR_UC_LO] = bits[`ASR_OC_HI:`ASR_UC_LO];
    w[`ASR_OV_HI:`ASR_UV_LO] = bits[`ASR_OV_HI:`ASR_UV_LO];
    w[`ASR_OP_HI:`ASR_OP_LO] = bits[`ASR_OP_HI:`ASR_OP_LO];
    w[`ASR_ACCUM_OVERFLOW_FLAG_BIT] = bits[`ASR_ACCUM_OVERFLOW_FLAG_BIT];
    w[`ASR_CNT_OVF_BIT] = bits[`ASR_CNT_OVF_BIT];
    w[`ASR_CONV_DONE_BIT] = bits[`ASR_CONV_DONE_BIT];
    route_view = w & `ASR_ROUTE_MASK_IMPL;
  endfunction

  assign status_rd = reg_rd_i & addr_hit(reg_addr_i, `ASR_TRIP_FLAGS_OFS);
  assign route_wr = reg_wr_i & addr_hit(reg_addr_i, `ASR_ROUTE_MASK_OFS);

  // bit 1 of the flag store holds the conversion-done source for the pin only
  assign trip_set = pack_conditions(chan_overcurrent_i, chan_undercurrent_i,
                                    chan_overvoltage_i, chan_undervoltage_i,
                                    chan_overpower_i, accum_overflow_i,
                                    sample_counter_overflow_i, conversion_done_i);

  // clear sequencing
  always_comb begin
    next_clr_state = clr_state;
    case (clr_state)
      ASR_CLR_IDLE: begin
        if (status_rd) begin
          next_clr_state = ASR_CLR_ARMED;
        end
      end
      ASR_CLR_ARMED: begin
        if (conversion_done_i && !status_rd) begin
          next_clr_state = ASR_CLR_IDLE;
        end
      end
      default: begin
        next_clr_state = ASR_CLR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      clr_state <= ASR_CLR_IDLE;
    end else begin
      clr_state <= next_clr_state;
    end
  end

  // a completed conversion while armed releases the flags in the snapshot
  assign clear_now = (clr_state == ASR_CLR_ARMED) && conversion_done_i;

  // besides bit 1, only flags the host has actually seen are cleared; later trips survive
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      read_snapshot <= '0;
    end else if (status_rd) begin
      read_snapshot <= status_view(trip_flags);
    end else if (clear_now) begin
      read_snapshot <= '0;
    end
  end

  always_comb begin
    trip_clr = '0;
    if (clear_now) begin
      trip_clr = read_snapshot;
    end
    // conversion-done source drops on any status read
    trip_clr[`ASR_CONV_DONE_BIT] = status_rd;
  end

  asr_trip_flags #(
    .WIDTH(`ASR_REG_W)
  ) u_flags (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .set_i(trip_set),
    .clr_i(trip_clr),
    .flags_o(trip_flags)
  );

  assign pin_sources = route_view(trip_flags);

  asr_pin_route u_route (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .mask_wr_i(route_wr),
    .mask_wdata_i(reg_wdata_i),
    .sources_i(pin_sources),
    .alert_function_sel_i(alert_function_sel_i),
    .route_mask_o(route_mask),
    .first_alert_pin_o(first_alert_pin_o)
  );

  // read mux; unmapped addresses read zero, status writes are ignored
  always_comb begin
    next_rdata = '0;
    if (addr_hit(reg_addr_i, `ASR_TRIP_FLAGS_OFS)) begin
      next_rdata = status_view(trip_flags);
    end else if (addr_hit(reg_addr_i, `ASR_ROUTE_MASK_OFS)) begin
      next_rdata = route_view(route_mask);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

endmodule // asr_top

// ---- dv/asr_chk_asserts.sv ----
`timescale 1ns/10ps
module asr_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire asr_pkg::asr_addr_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire asr_pkg::asr_word_t reg_wdata_i,
  input wire asr_pkg::asr_word_t reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire asr_pkg::asr_chan_t chan_overvoltage_i,
  input wire asr_pkg::asr_chan_t chan_undervoltage_i,
  input wire asr_pkg::asr_chan_t chan_overpower_i,
  input wire logic accum_overflow_i,
  input wire logic alert_function_sel_i,
  input wire logic first_alert_pin_o
);
  import asr_pkg::*;
  asr_word_t mask;
  // shadow of the route mask, so routing can be judged without peeking inside
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      mask <= 24'h000000;
    else if (reg_wr_i && reg_addr_i == 8'h27)
      mask <= reg_wdata_i & 24'hfffffe;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_stat_rd;
    reg_rd_i && reg_addr_i == 8'h26;
  endsequence
  sequence s_mask_rd;
    reg_rd_i && reg_addr_i == 8'h27 && !reg_wr_i;
  endsequence
  a_ov_flag_set: assert property (chan_overvoltage_i[2] ##1 s_stat_rd |=> reg_rdata_o[14])
    else $error("overvoltage flag missing");
  a_uv_flag_set: assert property (chan_undervoltage_i[3] ##1 s_stat_rd |=> reg_rdata_o[11])
    else $error("undervoltage flag missing");
  a_op_flag_set: assert property (chan_overpower_i[0] ##1 s_stat_rd |=> reg_rdata_o[4])
    else $error("overpower flag missing");
  a_acc_flag_set: assert property (accum_overflow_i ##1 s_stat_rd |=> reg_rdata_o[3])
    else $error("accumulator flag missing");
  a_status_low_zero: assert property (s_stat_rd |=> reg_rvalid_o && reg_rdata_o[1:0] == 2'b00)
    else $error("status low bits not zero");
  a_bit0_zero: assert property (reg_rvalid_o |-> !reg_rdata_o[0])
    else $error("bit 0 read as one");
  a_mask_readback: assert property (s_mask_rd |=> reg_rdata_o == $past(mask))
    else $error("route mask readback wrong");
  a_pin_off_sel: assert property (!alert_function_sel_i |=> !first_alert_pin_o)
    else $error("pin driven without alert function");
  a_pin_routed_trip: assert property (chan_overpower_i[3] && alert_function_sel_i && mask[7]
    ##1 alert_function_sel_i && mask[7] |=> first_alert_pin_o)
    else $error("routed trip did not raise pin");
endmodule // asr_chk

// ---- dv/asr_host.sv ----
`timescale 1ns/10ps
module asr_host (
  input wire logic clock_i, // system clock
  input wire asr_pkg::asr_word_t rdata_i, // read data
  input wire logic rvalid_i, // read data valid
  output asr_pkg::asr_addr_t addr_o, // register address
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  output asr_pkg::asr_word_t wdata_o // write data
);
  import asr_pkg::*;
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 24'h000000;
  end
  // sources are enabled, and limits changed only with alerts off, outside this block
  task automatic wr(input asr_addr_t a, input asr_word_t d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input asr_addr_t a, output asr_word_t d, output logic v);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clock_i);
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule // asr_host

// ---- dv/asr_top_tb_top.sv ----
`timescale 1ns/10ps
module asr_top_tb_top;
  import asr_pkg::*;
  logic clock_i, rst_i, conv, sel, wr, rd, rvalid, pin, v;
  asr_word_t cond, rdata, wdata, got;
  asr_addr_t addr;
  int mismatches, check_count;
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  asr_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .chan_overcurrent_i(cond[23:20]), .chan_undercurrent_i(cond[19:16]),
    .chan_overvoltage_i(cond[15:12]), .chan_undervoltage_i(cond[11:8]),
    .chan_overpower_i(cond[7:4]), .accum_overflow_i(cond[3]),
    .sample_counter_overflow_i(cond[2]), .conversion_done_i(conv),
    .alert_function_sel_i(sel), .first_alert_pin_o(pin));
  asr_host host_u (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  task automatic check(input asr_word_t s, input asr_word_t e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // a missing valid turns the word unknown so it can never match
  task automatic rchk(input asr_addr_t a, input asr_word_t e);
    host_u.rd(a, got, v);
    check(v === 1'b1 ? got : 24'hxxxxxx, e);
  endtask
  task automatic pchk(input logic e);
    repeat (2) @(posedge clock_i);
    check({23'h0, pin}, {23'h0, e});
  endtask
  task automatic pulse;
    @(posedge clock_i);
    conv <= 1'b1;
    @(posedge clock_i);
    conv <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end
  initial begin
    rst_i = 1'b1;
    conv = 1'b0;
    sel = 1'b1;
    cond = 24'h000000;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk(8'h26, 24'h000000);
    rchk(8'h27, 24'h000000);
    host_u.wr(8'h27, 24'hffffff);
    rchk(8'h27, 24'hfffffe);
    host_u.wr(8'h26, 24'hffffff);
    rchk(8'h26, 24'h000000);
    rchk(8'h30, 24'h000000);
    $display("test registers done");
    for (int i = 2; i < 24; i++) begin
      @(posedge clock_i);
      cond <= 24'h1 << i;
      rchk(8'h26, 24'h1 << i);
      pchk(1'b1);
      pulse;
      rchk(8'h26, 24'h1 << i);
      cond <= 24'h000000;
      pulse;
      rchk(8'h26, 24'h000000);
      pchk(1'b0);
    end
    $display("test flags done");
    sel <= 1'b0;
    cond <= 24'h000800;
    pchk(1'b0);
    sel <= 1'b1;
    pchk(1'b1);
    $display("test pin function done");
    host_u.wr(8'h27, 24'h000002);
    rchk(8'h27, 24'h000002);
    pchk(1'b0);
    pulse;
    pchk(1'b1);
    rchk(8'h26, 24'h000800);
    pchk(1'b0);
    $display("test routing done");
    print_verdict;
  end
endmodule // asr_top_tb_top
bind asr_top asr_chk chk_u (.clock_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .reg_rvalid_o, .chan_overvoltage_i, .chan_undervoltage_i, .chan_overpower_i,
  .accum_overflow_i, .alert_function_sel_i, .first_alert_pin_o);
